// File: rtl/fcp_defines.vh
// Constants for the flash configuration, power-down and ID command slice.
// Assumes a 25 MHz system clock; included by rtl/fcp_flash_cmd.v.
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH

// ****************************************************************
// Command opcodes.
// ****************************************************************
`define FCP_OP_CFG_WRITE   8'h11
`define FCP_OP_CFG_READ_A  8'h45
`define FCP_OP_CFG_READ_B  8'h15
`define FCP_OP_STATUS_READ 8'h05
`define FCP_OP_POWER_DOWN  8'hb9
`define FCP_OP_WAKE        8'hab
`define FCP_OP_ID_SINGLE   8'h90
`define FCP_OP_ID_DUAL     8'h92
`define FCP_OP_ID_QUAD     8'h94

// ****************************************************************
// Timing.
// ****************************************************************
`define FCP_CLK_PERIOD_NS       40
`define FCP_CFG_WRITE_TIME_NS   5000000
`define FCP_PD_ENTRY_DELAY_NS   3000
`define FCP_WAKE_PLAIN_NS       3000
`define FCP_WAKE_CODE_NS        1800
`define FCP_CFG_WRITE_CYCLES ((`FCP_CFG_WRITE_TIME_NS + `FCP_CLK_PERIOD_NS - 1) / `FCP_CLK_PERIOD_NS)
`define FCP_PD_ENTRY_CYCLES  ((`FCP_PD_ENTRY_DELAY_NS + `FCP_CLK_PERIOD_NS - 1) / `FCP_CLK_PERIOD_NS)
`define FCP_WAKE_PLAIN_CYCLES ((`FCP_WAKE_PLAIN_NS + `FCP_CLK_PERIOD_NS - 1) / `FCP_CLK_PERIOD_NS)
`define FCP_WAKE_CODE_CYCLES (`FCP_WAKE_CODE_NS / `FCP_CLK_PERIOD_NS)

// ****************************************************************
// Reset values and ID bytes.
// ****************************************************************
`define FCP_CFG_RESET  8'h00
`define FCP_ADDR_MAKER 8'h00
`define FCP_ADDR_DEV   8'h01

// ****************************************************************
// Command and power states and output byte sources.
// ****************************************************************
`define FCP_ST_IDLE 3'h0
`define FCP_ST_OPC  3'h1
`define FCP_ST_ADDR 3'h2
`define FCP_ST_DIN  3'h3
`define FCP_ST_OUT  3'h4
`define FCP_ST_HOLD 3'h5
`define FCP_ST_IGN  3'h6

`define FCP_PM_STANDBY 2'h0
`define FCP_PM_ENTER   2'h1
`define FCP_PM_DOWN    2'h2
`define FCP_PM_WAKE    2'h3

`define FCP_SRC_CFG  2'h0
`define FCP_SRC_STAT 2'h1
`define FCP_SRC_ID   2'h2
`define FCP_SRC_SIG  2'h3

`endif

// File: rtl/fcp_flash_cmd.v
// Command interpreter for configuration, power-down and ID commands.
// Assumes serial clock and chip select come from an outside host and
// are sampled by I_CLOCK; the rest of the device owns the write latch.
`timescale 1ns/1ns
`default_nettype none
`include "fcp_defines.vh"

module fcp_flash_cmd
#(
  parameter        CW_CYCLES   = `FCP_CFG_WRITE_CYCLES,
  parameter [7:0]  MAKER_CODE  = 8'h5a,
  parameter [7:0]  DEVICE_CODE = 8'h15
)
(
  input  wire        I_CLOCK,
  input  wire        I_RST_N,
  input  wire        I_CS_N,
  input  wire        I_SCLK,
  input  wire        I_DATA_LINE_0,
  input  wire        I_DATA_LINE_1,
  input  wire        I_DATA_LINE_2,
  input  wire        I_DATA_LINE_3,
  input  wire        I_WRITE_LATCH_BIT,
  input  wire        I_ARRAY_BUSY,
  input  wire        I_QUAD_LINES_ENABLE_BIT,
  output reg         O_DATA_LINE_0,
  output reg         O_DATA_LINE_1,
  output reg         O_DATA_LINE_2,
  output reg         O_DATA_LINE_3,
  output reg  [3:0]  O_DATA_LINE_OE,
  output reg         O_BUSY_FLAG,
  output reg         O_WRITE_LATCH_CLR,
  output reg         O_POWER_DOWN,
  output reg  [7:0]  O_CONFIG
);

  // MAKER_CODE and DEVICE_CODE defaults are arbitrary values.

  localparam [31:0] PD_CYC32  = `FCP_PD_ENTRY_CYCLES;
  localparam [31:0] WP_CYC32  = `FCP_WAKE_PLAIN_CYCLES;
  localparam [31:0] WC_CYC32  = `FCP_WAKE_CODE_CYCLES;
  localparam [31:0] CW_CYC32  = CW_CYCLES;
  localparam [19:0] PD_CYC    = PD_CYC32[19:0];
  localparam [19:0] WP_CYC    = WP_CYC32[19:0];
  localparam [19:0] WC_CYC    = WC_CYC32[19:0];
  localparam [19:0] CW_CYC    = CW_CYC32[19:0];

  // ****************************************************************
  // Input synchronisers and edge detection.
  // ****************************************************************
  reg  [5:0]  s1_r;
  reg  [5:0]  s2_r;
  reg         cs_d_r;
  reg         sclk_d_r;

  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      s1_r     <= 6'h20;
      s2_r     <= 6'h20;
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      s1_r     <= {I_CS_N, I_SCLK, I_DATA_LINE_3, I_DATA_LINE_2,
                   I_DATA_LINE_1, I_DATA_LINE_0};
      s2_r     <= s1_r;
      cs_d_r   <= s2_r[5];
      sclk_d_r <= s2_r[4];
    end
  end

  wire        cs_n      = s2_r[5];
  wire        sclk      = s2_r[4];
  wire [3:0]  din       = s2_r[3:0];
  wire        cs_fall   = ~cs_n & cs_d_r;
  wire        cs_rise   = cs_n & ~cs_d_r;
  wire        sclk_rise = ~cs_n & sclk & ~sclk_d_r;
  wire        sclk_fall = ~cs_n & ~sclk & sclk_d_r;

  // ****************************************************************
  // Command state.
  // ****************************************************************
  reg  [2:0]  st_r;
  reg  [7:0]  op_r;
  reg  [7:0]  sh_r;
  reg  [3:0]  bits_r;
  reg  [2:0]  bytes_r;
  reg  [2:0]  need_r;
  reg  [2:0]  lanes_r;
  reg  [1:0]  src_r;
  reg         alt_r;
  reg         alt_sw_r;
  reg  [7:0]  obyte_r;
  reg  [3:0]  obits_r;
  reg  [1:0]  pm_r;
  reg  [19:0] pm_tmr_r;
  reg         cw_busy_r;
  reg  [19:0] cw_tmr_r;
  reg  [7:0]  cfg_r;
  reg  [7:0]  cfg_new_r;
  reg         start_cw_r;
  reg         start_pd_r;
  reg         wake_plain_r;
  reg         wake_code_r;

  wire        busy_any  = cw_busy_r | I_ARRAY_BUSY;
  wire [7:0]  op_in     = {sh_r[6:0], din[0]};
  wire [7:0]  stat_byte = {6'h00, I_WRITE_LATCH_BIT, busy_any};

  reg  [7:0]  in_sh;
  reg  [3:0]  bits_nxt;
  reg  [2:0]  st_nxt;

  always @*
  begin
    in_sh    = {sh_r[6:0], din[0]};
    bits_nxt = bits_r + {1'b0, lanes_r};
    if (lanes_r == 3'h4)
    begin
      in_sh = {sh_r[3:0], din[3:0]};
    end
    else if (lanes_r == 3'h2)
    begin
      in_sh = {sh_r[5:0], din[1:0]};
    end
  end

  // Opcode decode gated by power and busy state.
  always @*
  begin
    st_nxt = `FCP_ST_IGN;
    if (pm_r == `FCP_PM_WAKE)
    begin
      st_nxt = `FCP_ST_IGN;
    end
    else if (pm_r != `FCP_PM_STANDBY)
    begin
      if (op_in == `FCP_OP_WAKE)
      begin
        st_nxt = `FCP_ST_ADDR;
      end
    end
    else
    begin
      case (op_in)
        `FCP_OP_CFG_WRITE:
          if (I_WRITE_LATCH_BIT && !busy_any)
            st_nxt = `FCP_ST_DIN;
        `FCP_OP_CFG_READ_A,
        `FCP_OP_CFG_READ_B,
        `FCP_OP_STATUS_READ:
          st_nxt = `FCP_ST_OUT;
        `FCP_OP_POWER_DOWN:
          if (!busy_any)
            st_nxt = `FCP_ST_HOLD;
        `FCP_OP_WAKE,
        `FCP_OP_ID_SINGLE,
        `FCP_OP_ID_DUAL:
          if (!busy_any)
            st_nxt = `FCP_ST_ADDR;
        `FCP_OP_ID_QUAD:
          if (!busy_any && I_QUAD_LINES_ENABLE_BIT)
            st_nxt = `FCP_ST_ADDR;
        default:
          st_nxt = `FCP_ST_IGN;
      endcase
    end
  end

  // ****************************************************************
  // Serial input, decode and chip select handling.
  // ****************************************************************
  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      st_r         <= `FCP_ST_IDLE;
      op_r         <= 8'h00;
      sh_r         <= 8'h00;
      bits_r       <= 4'h0;
      bytes_r      <= 3'h0;
      need_r       <= 3'h3;
      lanes_r      <= 3'h1;
      src_r        <= `FCP_SRC_CFG;
      alt_r        <= 1'b0;
      cfg_new_r    <= `FCP_CFG_RESET;
      start_cw_r   <= 1'b0;
      start_pd_r   <= 1'b0;
      wake_plain_r <= 1'b0;
      wake_code_r  <= 1'b0;
    end
    else
    begin
      start_cw_r   <= 1'b0;
      start_pd_r   <= 1'b0;
      wake_plain_r <= 1'b0;
      wake_code_r  <= 1'b0;
      if (alt_sw_r)
      begin
        alt_r <= ~alt_r;
      end
      if (cs_fall)
      begin
        st_r    <= `FCP_ST_OPC;
        bits_r  <= 4'h0;
        bytes_r <= 3'h0;
        lanes_r <= 3'h1;
      end
      else if (cs_rise)
      begin
        if (st_r == `FCP_ST_DIN && op_r == `FCP_OP_CFG_WRITE && bits_r == 4'h0
            && bytes_r == 3'h1)
        begin
          start_cw_r <= 1'b1;
        end
        if (st_r == `FCP_ST_HOLD)
        begin
          start_pd_r <= 1'b1;
        end
        if (op_r == `FCP_OP_WAKE && st_r != `FCP_ST_IGN && st_r != `FCP_ST_OPC)
        begin
          if (st_r == `FCP_ST_ADDR && bits_r == 4'h0 && bytes_r == 3'h0)
            wake_plain_r <= 1'b1;
          else
            wake_code_r <= 1'b1;
        end
        st_r <= `FCP_ST_IDLE;
      end
      else if (sclk_rise)
      begin
        case (st_r)
          `FCP_ST_OPC:
          begin
            sh_r <= op_in;
            if (bits_r == 4'h7)
            begin
              op_r   <= op_in;
              bits_r <= 4'h0;
              st_r   <= st_nxt;
              need_r <= (op_in == `FCP_OP_ID_QUAD) ? 3'h5 : 3'h3;
              if (op_in == `FCP_OP_ID_DUAL)
                lanes_r <= 3'h2;
              else if (op_in == `FCP_OP_ID_QUAD)
                lanes_r <= 3'h4;
              src_r <= (op_in == `FCP_OP_STATUS_READ) ? `FCP_SRC_STAT : `FCP_SRC_CFG;
            end
            else
            begin
              bits_r <= bits_r + 4'h1;
            end
          end
          `FCP_ST_ADDR,
          `FCP_ST_DIN:
          begin
            sh_r <= in_sh;
            if (bits_nxt == 4'h8)
            begin
              bits_r  <= 4'h0;
              bytes_r <= bytes_r + 3'h1;
              if (st_r == `FCP_ST_DIN)
              begin
                cfg_new_r <= in_sh;
              end
              else
              begin
                if (bytes_r == 3'h2)
                  alt_r <= (in_sh == `FCP_ADDR_DEV);
                if (bytes_r == need_r - 3'h1)
                begin
                  st_r  <= `FCP_ST_OUT;
                  src_r <= (op_r == `FCP_OP_WAKE) ? `FCP_SRC_SIG : `FCP_SRC_ID;
                end
              end
            end
            else
            begin
              bits_r <= bits_nxt;
            end
          end
          `FCP_ST_HOLD:
            st_r <= `FCP_ST_IGN;
          default:
            st_r <= st_r;
        endcase
      end
    end
  end

  // ****************************************************************
  // Serial output on falling clock edges.
  // ****************************************************************
  reg  [7:0]  nb;
  reg  [7:0]  cur;

  always @*
  begin
    case (src_r)
      `FCP_SRC_CFG:  nb = cfg_r;
      `FCP_SRC_STAT: nb = stat_byte;
      `FCP_SRC_ID:   nb = alt_r ? DEVICE_CODE : MAKER_CODE;
      default:       nb = DEVICE_CODE;
    endcase
    cur = (obits_r == 4'h0) ? nb : obyte_r;
  end

  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      obyte_r        <= 8'h00;
      obits_r        <= 4'h0;
      O_DATA_LINE_0  <= 1'b0;
      O_DATA_LINE_1  <= 1'b0;
      O_DATA_LINE_2  <= 1'b0;
      O_DATA_LINE_3  <= 1'b0;
      O_DATA_LINE_OE <= 4'h0;
    end
    else if (cs_n || st_r != `FCP_ST_OUT)
    begin
      obits_r        <= 4'h0;
      O_DATA_LINE_OE <= 4'h0;
    end
    else if (sclk_fall)
    begin
      if (lanes_r == 3'h4)
      begin
        {O_DATA_LINE_3, O_DATA_LINE_2, O_DATA_LINE_1, O_DATA_LINE_0} <= cur[7:4];
        O_DATA_LINE_OE <= 4'hf;
        obyte_r        <= {cur[3:0], 4'h0};
      end
      else if (lanes_r == 3'h2)
      begin
        {O_DATA_LINE_1, O_DATA_LINE_0} <= cur[7:6];
        O_DATA_LINE_OE <= 4'h3;
        obyte_r        <= {cur[5:0], 2'h0};
      end
      else
      begin
        O_DATA_LINE_1  <= cur[7];
        O_DATA_LINE_OE <= 4'h2;
        obyte_r        <= {cur[6:0], 1'b0};
      end
      obits_r <= ((obits_r == 4'h0) ? 4'h8 : obits_r) - {1'b0, lanes_r};
    end
  end

  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      alt_sw_r <= 1'b0;
    end
    else
    begin
      alt_sw_r <= sclk_fall && st_r == `FCP_ST_OUT && obits_r == 4'h0
                  && src_r == `FCP_SRC_ID;
    end
  end

  // ****************************************************************
  // Configuration write cycle and power state.
  // ****************************************************************
  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      cw_busy_r         <= 1'b0;
      cw_tmr_r          <= 20'h00000;
      cfg_r             <= `FCP_CFG_RESET;
      O_WRITE_LATCH_CLR <= 1'b0;
      O_BUSY_FLAG       <= 1'b0;
      O_CONFIG          <= `FCP_CFG_RESET;
    end
    else
    begin
      O_WRITE_LATCH_CLR <= 1'b0;
      if (start_cw_r)
      begin
        cw_busy_r <= 1'b1;
        cw_tmr_r  <= CW_CYC;
      end
      else if (cw_busy_r)
      begin
        if (cw_tmr_r == 20'h00001)
        begin
          cw_busy_r         <= 1'b0;
          cfg_r             <= cfg_new_r;
          O_WRITE_LATCH_CLR <= 1'b1;
        end
        cw_tmr_r <= cw_tmr_r - 20'h00001;
      end
      O_BUSY_FLAG <= start_cw_r | (cw_busy_r & cw_tmr_r != 20'h00001);
      O_CONFIG    <= cfg_r;
    end
  end

  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      pm_r         <= `FCP_PM_STANDBY;
      pm_tmr_r     <= 20'h00000;
      O_POWER_DOWN <= 1'b0;
    end
    else
    begin
      case (pm_r)
        `FCP_PM_STANDBY:
          if (start_pd_r)
          begin
            pm_r     <= `FCP_PM_ENTER;
            pm_tmr_r <= PD_CYC;
          end
        `FCP_PM_ENTER,
        `FCP_PM_WAKE:
        begin
          pm_tmr_r <= pm_tmr_r - 20'h00001;
          if (pm_tmr_r == 20'h00001)
            pm_r <= (pm_r == `FCP_PM_ENTER) ? `FCP_PM_DOWN : `FCP_PM_STANDBY;
        end
        `FCP_PM_DOWN:
          if (wake_plain_r || wake_code_r)
          begin
            pm_r     <= `FCP_PM_WAKE;
            pm_tmr_r <= wake_plain_r ? WP_CYC : WC_CYC;
          end
        default:
          pm_r <= `FCP_PM_STANDBY;
      endcase
      O_POWER_DOWN <= (pm_r == `FCP_PM_DOWN) && !wake_plain_r && !wake_code_r;
    end
  end

endmodule

`default_nettype wire

// File: dv/fcp_flash_cmd_properties.sv
// Concurrent checks on the ports of the command slice.
// Bound into fcp_flash_cmd; CW_CYCLES follows the instance value.
`timescale 1ns/1ns
`default_nettype none

module fcp_flash_cmd_props
#(
  parameter int CW_CYCLES = 50
)
(
  input wire logic       I_CLOCK,
  input wire logic       I_RST_N,
  input wire logic       I_CS_N,
  input wire logic       I_WRITE_LATCH_BIT,
  input wire logic       I_QUAD_LINES_ENABLE_BIT,
  input wire logic [3:0] O_DATA_LINE_OE,
  input wire logic       O_BUSY_FLAG,
  input wire logic       O_WRITE_LATCH_CLR,
  input wire logic       O_POWER_DOWN,
  input wire logic [7:0] O_CONFIG
);
  // ****************************************************************
  // Busy run counter and checks.
  // ****************************************************************
  int run_r;

  always @(posedge I_CLOCK)
  begin
    if (!I_RST_N || !O_BUSY_FLAG)
      run_r <= 0;
    else
      run_r <= run_r + 1;
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  AST_OE_IDLE: assert property (I_CS_N [*6] |-> O_DATA_LINE_OE == 4'h0)
    else $error("output enable while deselected");
  AST_OE_SHAPE: assert property (O_DATA_LINE_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal output enable pattern");
  AST_QUAD_QE: assert property (O_DATA_LINE_OE == 4'hf |-> I_QUAD_LINES_ENABLE_BIT)
    else $error("quad output without quad enable");
  AST_BUSY_START: assert property ($rose(O_BUSY_FLAG) |-> I_CS_N && I_WRITE_LATCH_BIT)
    else $error("busy started without latch or deselect");
  AST_BUSY_LEN: assert property ($fell(O_BUSY_FLAG) |-> run_r inside {[CW_CYCLES-2:CW_CYCLES+2]})
    else $error("busy run length wrong");
  AST_CLR_AFTER: assert property ($fell(O_BUSY_FLAG) |-> ##[0:2] O_WRITE_LATCH_CLR)
    else $error("latch clear missing after write");
  AST_CLR_PULSE: assert property (O_WRITE_LATCH_CLR |-> !O_BUSY_FLAG ##1 !O_WRITE_LATCH_CLR)
    else $error("latch clear pulse malformed");
  AST_CFG_HOLD: assert property (O_BUSY_FLAG |-> $stable(O_CONFIG))
    else $error("config changed during write");
  AST_PD_ON_DESEL: assert property ($rose(O_POWER_DOWN) |-> I_CS_N)
    else $error("power-down entered while selected");
  AST_PD_NOT_BUSY: assert property (O_POWER_DOWN |-> !O_BUSY_FLAG)
    else $error("write running in power-down");
endmodule

bind fcp_flash_cmd fcp_flash_cmd_props #(.CW_CYCLES(CW_CYCLES)) u_props (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N),
  .I_WRITE_LATCH_BIT(I_WRITE_LATCH_BIT), .I_QUAD_LINES_ENABLE_BIT(I_QUAD_LINES_ENABLE_BIT),
  .O_DATA_LINE_OE(O_DATA_LINE_OE), .O_BUSY_FLAG(O_BUSY_FLAG),
  .O_WRITE_LATCH_CLR(O_WRITE_LATCH_CLR), .O_POWER_DOWN(O_POWER_DOWN), .O_CONFIG(O_CONFIG)
);
`default_nettype wire

// File: dv/fcp_host_model.sv
// Host controller model that runs whole frames on the serial link.
// Assumes a 40 ns clock; the link clock period is 8 clocks.
`timescale 1ns/1ns
`default_nettype none

module fcp_host_model (
  input  wire logic        clk,
  input  wire logic [3:0]  line,
  output var  logic        cs_n,
  output var  logic        sclk,
  output var  logic [3:0]  hd,
  output var  logic [3:0]  hoe,
  output var  logic        res_v,
  output var  logic [31:0] res_d
);
  // ****************************************************************
  // Frame tasks.
  // ****************************************************************
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hd = 4'h0;
    hoe = 4'h0;
    res_v = 1'b0;
    res_d = 32'h0;
  end

  task automatic half(input logic s);
    sclk <= s;
    repeat (4) @(posedge clk);
  endtask

  task automatic frame(input logic [7:0] op, input int nin, input int w,
                       input logic [47:0] din, input int nout, input int wo, input logic want);
    logic [55:0] sh;
    logic [31:0] got;
    int          k;
    int          u;
    sh = {op, din};
    got = 32'h0;
    @(posedge clk);
    cs_n <= 1'b0;
    for (k = 0; k < 8 + nin; k += u)
    begin
      u = (k < 8) ? 1 : w;
      hoe <= 4'((1 << u) - 1);
      hd <= 4'(sh[55:52] >> (4 - u));
      sh = sh << u;
      half(1'b0);
      half(1'b1);
    end
    hoe <= 4'h0;
    for (k = 0; k < nout; k += wo)
    begin
      half(1'b0);
      sclk <= 1'b1;
      @(posedge clk);
      got = (got << wo) | 32'((wo == 1) ? {3'b0, line[1]} : (wo == 2) ? {2'b0, line[1:0]} : line);
      repeat (3) @(posedge clk);
    end
    sclk <= 1'b0;
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
    if (want)
    begin
      res_d <= got;
      res_v <= 1'b1;
      @(posedge clk);
      res_v <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/fcp_flash_cmd_bench.sv
// Self-checking bench for the command slice.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("wrong value t=%0t got=%h exp=%h", $time, a, e); end end

module fcp_flash_cmd_bench;
  // ****************************************************************
  // Stimulus, link wiring and result watcher.
  // ****************************************************************
  localparam logic [7:0] MK = 8'h5a;  // Arbitrary maker code.
  localparam logic [7:0] DV = 8'h15;  // Arbitrary device code.
  logic        clk = 0, rst_n = 0, latch = 0, abusy = 0, qe = 0, tog = 0, snap_v = 0;
  wire logic   cs_n, sclk, res_v, busy, wclr, pd;
  wire logic [3:0] hd, hoe, oe, dout, line;
  wire logic [31:0] res_d;
  wire logic [7:0] cfg;
  logic [31:0] expq[$];
  logic [31:0] ev;
  logic [7:0]  cfgv, ad;
  int          fail_count = 0, checked = 0, cyc = 0, m, a, k;

  assign line = (oe & dout) | (~oe & hoe & hd) | (~oe & ~hoe & {4{tog}});
  always #20 clk = ~clk;
  always @(posedge clk) tog <= ~tog;

  fcp_flash_cmd #(.CW_CYCLES(400), .MAKER_CODE(MK), .DEVICE_CODE(DV)) DUT (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
    .I_DATA_LINE_0(line[0]), .I_DATA_LINE_1(line[1]), .I_DATA_LINE_2(line[2]),
    .I_DATA_LINE_3(line[3]), .I_WRITE_LATCH_BIT(latch), .I_ARRAY_BUSY(abusy),
    .I_QUAD_LINES_ENABLE_BIT(qe), .O_DATA_LINE_0(dout[0]), .O_DATA_LINE_1(dout[1]),
    .O_DATA_LINE_2(dout[2]), .O_DATA_LINE_3(dout[3]), .O_DATA_LINE_OE(oe),
    .O_BUSY_FLAG(busy), .O_WRITE_LATCH_CLR(wclr), .O_POWER_DOWN(pd), .O_CONFIG(cfg));

  fcp_host_model H (.clk(clk), .line(line), .cs_n(cs_n), .sclk(sclk), .hd(hd), .hoe(hoe),
    .res_v(res_v), .res_d(res_d));

  function automatic logic [31:0] st(input logic p, input logic b, input logic [7:0] c);
    return {22'h0, p, b, c};
  endfunction

  task automatic snap(input logic [31:0] v);
    expq.push_back(v);
    snap_v <= 1'b1;
    @(posedge clk);
    snap_v <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test;
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      finish_test();
    end
    if (res_v || snap_v)
    begin
      ev = expq.pop_front();
      if (res_v)
        `CHK(res_d, ev)
      else
        `CHK(st(pd, busy, cfg), ev)
    end
  end

  initial
  begin
    void'($urandom(32'h017cacd5));
    cfgv = 8'($urandom);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    snap(st(0, 0, 8'h00));
    H.frame(8'h11, 8, 1, {cfgv, 40'h0}, 0, 1, 0);
    repeat (20) @(posedge clk);
    snap(st(0, 0, 8'h00));
    latch <= 1'b1;
    for (m = 7; m <= 16; m += 9)
    begin
      H.frame(8'h11, m, 1, {cfgv, cfgv, 32'h0}, 0, 1, 0);
      repeat (20) @(posedge clk);
      snap(st(0, 0, 8'h00));
    end
    H.frame(8'h11, 8, 1, {cfgv, 40'h0}, 0, 1, 0);
    snap(st(0, 1, 8'h00));
    expq.push_back(32'h03);
    H.frame(8'h05, 0, 1, 48'h0, 8, 1, 1);
    abusy <= 1'b1;
    expq.push_back(32'h00);
    H.frame(8'h45, 0, 1, 48'h0, 8, 1, 1);
    abusy <= 1'b0;
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
    latch <= 1'b0;
    snap(st(0, 0, cfgv));
    for (m = 0; m < 2; m++)
    begin
      expq.push_back({16'h0, cfgv, cfgv});
      H.frame(m == 0 ? 8'h45 : 8'h15, 0, 1, 48'h0, 16, 1, 1);
    end
    expq.push_back({16'h0, DV, DV});
    H.frame(8'hab, 24, 1, 48'h0, 16, 1, 1);
    abusy <= 1'b1;
    H.frame(8'hb9, 0, 1, 48'h0, 0, 1, 0);
    repeat (100) @(posedge clk);
    snap(st(0, 0, cfgv));
    abusy <= 1'b0;
    H.frame(8'hb9, 1, 1, 48'h0, 0, 1, 0);
    repeat (100) @(posedge clk);
    snap(st(0, 0, cfgv));
    H.frame(8'hb9, 0, 1, 48'h0, 0, 1, 0);
    repeat (100) @(posedge clk);
    snap(st(1, 0, cfgv));
    latch <= 1'b1;
    H.frame(8'h11, 8, 1, {~cfgv, 40'h0}, 0, 1, 0);
    repeat (20) @(posedge clk);
    snap(st(1, 0, cfgv));
    latch <= 1'b0;
    H.frame(8'hab, 0, 1, 48'h0, 0, 1, 0);
    repeat (100) @(posedge clk);
    snap(st(0, 0, cfgv));
    H.frame(8'hb9, 0, 1, 48'h0, 0, 1, 0);
    repeat (100) @(posedge clk);
    expq.push_back({24'h0, DV});
    H.frame(8'hab, 24, 1, 48'h0, 8, 1, 1);
    repeat (60) @(posedge clk);
    snap(st(0, 0, cfgv));
    qe <= 1'b1;
    for (m = 0; m < 3; m++)
      for (a = 0; a < 3; a++)
      begin
        ad = (a == 2) ? 8'($urandom_range(255, 2)) : 8'(a);
        expq.push_back(ad == 8'h01 ? {DV, MK, DV, MK} : {MK, DV, MK, DV});
        H.frame(8'h90 + 8'(2 * m), m == 2 ? 40 : 24, 1 << m, {16'h0, ad, 24'h0}, 32, 1 << m, 1);
      end
    qe <= 1'b0;
    H.frame(8'h94, 40, 4, 48'h0, 32, 4, 0);
    finish_test();
  end
endmodule
`default_nettype wire
